/* File: hdl/gric_top.sv */
// Remote interface control: port select, GPIB message state and clears.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`default_nettype none
module gric_top #(
  parameter int SHOW_CYC = gric_pkg::ADDR_SHOW_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic NV_INIT_N,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic PANEL_PORT_WR,
  input wire logic PANEL_PORT_VAL,
  input wire logic PANEL_LOCAL_KEY,
  input wire logic PANEL_OUTPUT_OFF_KEY,
  input wire logic [7:0] PANEL_KEYS,
  input wire logic GPIB_REN,
  input wire logic GPIB_IFC,
  input wire logic GPIB_MSG_VALID,
  input wire logic [3:0] GPIB_MSG,
  input wire logic [4:0] GPIB_MSG_ADDR,
  input wire logic RS232_CMD_VALID,
  output logic SEL_RS232,
  output logic GPIB_ENABLE,
  output logic RS232_ENABLE,
  output logic REMOTE_INDICATOR,
  output logic LOCKOUT,
  output logic TALK_INDICATOR,
  output logic LISTENER_INDICATOR,
  output logic SHOW_ADDR,
  output logic [4:0] SHOW_PAD,
  output logic [7:0] KEYS_OUT,
  output logic OUTPUT_OFF_REQ,
  output logic CLEAR_PULSE,
  output logic ARM_PULSE,
  output logic SPOLL_ACTIVE,
  output logic [7:0] SPOLL_BYTE,
  output logic ACQ_GO,
  output logic ACQ_REJECT,
  output logic ABORT_PULSE
);
  logic core_rst_n;
  logic rst_any_n;
  gric_nv_if nv ();

  gric_nvstore u_nv (
    .clk(REF_CLK),
    .nv_init_n(NV_INIT_N),
    .nv(nv)
  );

  gric_por #(.SHOW_CYC(SHOW_CYC)) u_por (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .restart(nv.port_changed),
    .core_rst_n(core_rst_n),
    .show_addr(SHOW_ADDR)
  );

  assign rst_any_n = RST_N && core_rst_n;

  logic rem_reg, rem_next;
  logic llo_reg, llo_next;
  logic tact_reg, tact_next;
  logic lact_reg, lact_next;
  logic spoll_reg, spoll_next;
  logic arm_bus_reg, arm_bus_next;
  logic auto_off_reg, auto_off_next;
  logic [7:0] stb_reg, stb_next;
  logic clr_reg, clr_next;
  logic arm_reg, arm_next;
  logic go_reg, go_next;
  logic rej_reg, rej_next;
  logic abort_reg, abort_next;
  logic offreq_reg, offreq_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] keys_reg, keys_next;
  logic rs_seen_reg, rs_seen_next;
  logic gpib_msg_ok;
  logic for_me;
  logic is_remote_port;

  assign is_remote_port = (nv.port_sel == gric_pkg::PORT_GPIB);
  // Traffic on the unselected port is dropped before decoding.
  assign gpib_msg_ok = GPIB_MSG_VALID && is_remote_port;
  assign for_me = (GPIB_MSG_ADDR == nv.pad);

  // Front panel writes the port select; the register bus writes the address and serial settings.
  always_comb begin
    nv.wr_port = PANEL_PORT_WR;
    nv.port_val = PANEL_PORT_VAL;
    nv.wr_pad = WR && ADDR == gric_pkg::REG_PAD;
    nv.pad_val = WDATA[4:0];
    nv.wr_ser = WR && ADDR == gric_pkg::REG_SERCFG;
    nv.baud_val = nv.baud;
    nv.dbits_val = WDATA[3:0];
    nv.parity_val = WDATA[5:4];
    nv.term_val = WDATA[15:8];
    nv.flow_val = WDATA[16];
    if (WR && ADDR == gric_pkg::REG_BAUD) begin
      nv.wr_ser = 1'b1;
      nv.baud_val = WDATA;
      nv.dbits_val = nv.dbits;
      nv.parity_val = nv.parity;
      nv.term_val = nv.term;
      nv.flow_val = nv.flow;
    end
  end

  always_comb begin
    rem_next = rem_reg;
    llo_next = llo_reg;
    tact_next = tact_reg;
    lact_next = lact_reg;
    spoll_next = spoll_reg;
    clr_next = 1'b0;
    arm_next = 1'b0;
    rs_seen_next = RS232_CMD_VALID && !is_remote_port;
    if (!GPIB_REN) begin
      rem_next = 1'b0;
    end
    if (gpib_msg_ok) begin
      case (GPIB_MSG)
        gric_pkg::MSG_MLA: begin
          if (for_me) begin
            lact_next = 1'b1;
            tact_next = 1'b0;
            if (GPIB_REN) begin
              rem_next = 1'b1;
            end
          end
        end
        gric_pkg::MSG_MTA: begin
          if (for_me) begin
            tact_next = 1'b1;
            lact_next = 1'b0;
          end else begin
            tact_next = 1'b0;
          end
        end
        gric_pkg::MSG_OTA: tact_next = 1'b0;
        gric_pkg::MSG_UNL: lact_next = 1'b0;
        gric_pkg::MSG_UNT: tact_next = 1'b0;
        gric_pkg::MSG_LLO: llo_next = 1'b1;
        gric_pkg::MSG_GTL: begin
          if (lact_reg) begin
            rem_next = 1'b0;
            llo_next = 1'b0;
          end
        end
        gric_pkg::MSG_DCL: clr_next = 1'b1;
        gric_pkg::MSG_SDC: clr_next = lact_reg;
        gric_pkg::MSG_GET: arm_next = lact_reg && arm_bus_reg;
        gric_pkg::MSG_SPE: spoll_next = 1'b1;
        gric_pkg::MSG_SPD: spoll_next = 1'b0;
        default: begin
        end
      endcase
    end
    if (PANEL_LOCAL_KEY && !llo_reg) begin
      rem_next = 1'b0;
    end
    // Only the talk, listen and serial-poll flags are touched; remote, lockout and settings stay.
    if (GPIB_IFC && is_remote_port) begin
      tact_next = 1'b0;
      lact_next = 1'b0;
      spoll_next = 1'b0;
    end
  end

  always_comb begin
    arm_bus_next = arm_bus_reg;
    auto_off_next = auto_off_reg;
    stb_next = stb_reg;
    go_next = 1'b0;
    rej_next = 1'b0;
    abort_next = 1'b0;
    offreq_next = PANEL_OUTPUT_OFF_KEY;
    keys_next = PANEL_KEYS;
    rdata_next = 32'h0000_0000;
    if (rem_reg || llo_reg) begin
      keys_next = 8'h00;
    end
    if (WR && ADDR == gric_pkg::REG_CONTROL) begin
      arm_bus_next = WDATA[0];
      auto_off_next = WDATA[1];
    end
    if (WR && ADDR == gric_pkg::REG_STB) begin
      stb_next = WDATA[7:0];
    end
    if (WR && ADDR == gric_pkg::REG_CMD) begin
      // Abort never forces the output off, even with auto-off on.
      if (WDATA[1:0] == gric_pkg::ACQ_ABORT) begin
        abort_next = 1'b1;
      end else if (rem_reg || rs_seen_reg || !is_remote_port) begin
        go_next = 1'b1;
      end else begin
        rej_next = 1'b1;
      end
    end
    if (clr_reg) begin
      go_next = 1'b0;
    end
    if (RD) begin
      case (ADDR)
        gric_pkg::REG_STATUS: rdata_next = {24'h00_0000, SHOW_ADDR,
          spoll_reg, nv.port_sel, lact_reg, tact_reg, llo_reg,
          rem_reg, arm_bus_reg};
        gric_pkg::REG_CONTROL: rdata_next = {30'h0000_0000,
          auto_off_reg, arm_bus_reg};
        gric_pkg::REG_BAUD: rdata_next = nv.baud;
        gric_pkg::REG_SERCFG: rdata_next = {15'h0000, nv.flow, nv.term,
          2'b00, nv.parity, nv.dbits};
        gric_pkg::REG_PAD: rdata_next = {27'h000_0000, nv.pad};
        gric_pkg::REG_STB: rdata_next = {24'h00_0000, stb_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!rst_any_n) begin
      rem_reg <= 1'b0;
      llo_reg <= 1'b0;
      tact_reg <= 1'b0;
      lact_reg <= 1'b0;
      spoll_reg <= 1'b0;
      clr_reg <= 1'b0;
      arm_reg <= 1'b0;
      rs_seen_reg <= 1'b0;
      arm_bus_reg <= 1'b0;
      auto_off_reg <= 1'b0;
      stb_reg <= 8'h00;
      go_reg <= 1'b0;
      rej_reg <= 1'b0;
      abort_reg <= 1'b0;
      offreq_reg <= 1'b0;
      keys_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      rem_reg <= rem_next;
      llo_reg <= llo_next;
      tact_reg <= tact_next;
      lact_reg <= lact_next;
      spoll_reg <= spoll_next;
      clr_reg <= clr_next;
      arm_reg <= arm_next;
      rs_seen_reg <= rs_seen_next;
      arm_bus_reg <= arm_bus_next;
      auto_off_reg <= auto_off_next;
      stb_reg <= stb_next;
      go_reg <= go_next;
      rej_reg <= rej_next;
      abort_reg <= abort_next;
      offreq_reg <= offreq_next;
      keys_reg <= keys_next;
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA = rdata_reg;
  assign SEL_RS232 = nv.port_sel;
  assign GPIB_ENABLE = is_remote_port;
  assign RS232_ENABLE = !is_remote_port;
  assign REMOTE_INDICATOR = rem_reg;
  assign LOCKOUT = llo_reg;
  assign TALK_INDICATOR = tact_reg;
  assign LISTENER_INDICATOR = lact_reg;
  assign SHOW_PAD = nv.pad;
  assign KEYS_OUT = keys_reg;
  assign OUTPUT_OFF_REQ = offreq_reg;
  assign CLEAR_PULSE = clr_reg;
  assign ARM_PULSE = arm_reg;
  assign SPOLL_ACTIVE = spoll_reg;
  assign SPOLL_BYTE = stb_reg;
  assign ACQ_GO = go_reg;
  assign ACQ_REJECT = rej_reg;
  assign ABORT_PULSE = abort_reg;
endmodule : gric_top
`default_nettype wire

/* File: hdl/gric_pkg.sv */
// Package of constants and types for the remote interface control block.
`default_nettype none
package gric_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int ADDR_SHOW_MS = 1000;
  localparam int ADDR_SHOW_CYC = CLK_HZ / 1000 * ADDR_SHOW_MS;
  localparam int POR_CYC = 16;
  localparam logic [4:0] PAD_DEFAULT = 5'h18;
  localparam logic [4:0] PAD_MAX = 5'h1E;
  localparam logic [31:0] BAUD_DEFAULT = 32'h0000_2580;
  localparam logic [3:0] DBITS_DEFAULT = 4'h8;
  localparam logic [7:0] TERM_DEFAULT = 8'h0D;
  localparam logic PORT_GPIB = 1'b0;
  localparam logic PORT_RS232 = 1'b1;
  // Register map of the plain bus.
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h1;
  localparam logic [3:0] REG_BAUD = 4'h2;
  localparam logic [3:0] REG_SERCFG = 4'h3;
  localparam logic [3:0] REG_PAD = 4'h4;
  localparam logic [3:0] REG_STB = 4'h5;
  localparam logic [3:0] REG_CMD = 4'h6;
  // Bus message codes arriving from the GPIB transceiver.
  typedef enum logic [3:0] {
    MSG_NONE = 4'b0000,
    MSG_MLA = 4'b0001,
    MSG_MTA = 4'b0010,
    MSG_UNL = 4'b0011,
    MSG_UNT = 4'b0100,
    MSG_LLO = 4'b0101,
    MSG_GTL = 4'b0110,
    MSG_DCL = 4'b0111,
    MSG_SDC = 4'b1000,
    MSG_GET = 4'b1001,
    MSG_SPE = 4'b1010,
    MSG_SPD = 4'b1011,
    MSG_OTA = 4'b1100
  } gric_msg_t;
  // Acquisition command codes written to the command register.
  typedef enum logic [1:0] {
    ACQ_INIT = 2'b00,
    ACQ_READ = 2'b01,
    ACQ_MEAS = 2'b10,
    ACQ_ABORT = 2'b11
  } gric_acq_t;
  typedef enum logic [1:0] {
    PS_RESET = 2'b00,
    PS_SHOW = 2'b01,
    PS_RUN = 2'b10
  } gric_pwr_t;
endpackage : gric_pkg
`default_nettype wire

/* File: hdl/gric_nv_if.sv */
// Interface carrying the non-volatile settings between modules.
`default_nettype none
interface gric_nv_if;
  logic port_sel;
  logic [4:0] pad;
  logic [31:0] baud;
  logic [3:0] dbits;
  logic [1:0] parity;
  logic [7:0] term;
  logic flow;
  logic wr_port;
  logic port_val;
  logic wr_pad;
  logic [4:0] pad_val;
  logic wr_ser;
  logic [31:0] baud_val;
  logic [3:0] dbits_val;
  logic [1:0] parity_val;
  logic [7:0] term_val;
  logic flow_val;
  logic port_changed;
  modport store (input wr_port, port_val, wr_pad, pad_val, wr_ser,
    baud_val, dbits_val, parity_val, term_val, flow_val,
    output port_sel, pad, baud, dbits, parity, term, flow, port_changed);
  modport user (output wr_port, port_val, wr_pad, pad_val, wr_ser,
    baud_val, dbits_val, parity_val, term_val, flow_val,
    input port_sel, pad, baud, dbits, parity, term, flow, port_changed);
endinterface : gric_nv_if
`default_nettype wire

/* File: hdl/gric_nvstore.sv */
// Settings store that keeps its contents across the block reset.
`default_nettype none
module gric_nvstore (
  input wire logic clk,
  input wire logic nv_init_n,
  gric_nv_if.store nv
);
  logic port_reg, port_next;
  logic [4:0] pad_reg, pad_next;
  logic [31:0] baud_reg, baud_next;
  logic [3:0] dbits_reg, dbits_next;
  logic [1:0] parity_reg, parity_next;
  logic [7:0] term_reg, term_next;
  logic flow_reg, flow_next;
  logic chg_reg, chg_next;

  // Only the factory init reloads the defaults; the block reset never touches it.
  always_comb begin
    port_next = port_reg;
    pad_next = pad_reg;
    baud_next = baud_reg;
    dbits_next = dbits_reg;
    parity_next = parity_reg;
    term_next = term_reg;
    flow_next = flow_reg;
    chg_next = 1'b0;
    if (!nv_init_n) begin
      port_next = gric_pkg::PORT_GPIB;
      pad_next = gric_pkg::PAD_DEFAULT;
      baud_next = gric_pkg::BAUD_DEFAULT;
      dbits_next = gric_pkg::DBITS_DEFAULT;
      parity_next = 2'b00;
      term_next = gric_pkg::TERM_DEFAULT;
      flow_next = 1'b0;
    end else begin
      if (nv.wr_port && nv.port_val != port_reg) begin
        port_next = nv.port_val;
        chg_next = 1'b1;
      end
      if (nv.wr_pad && nv.pad_val <= gric_pkg::PAD_MAX) begin
        pad_next = nv.pad_val;
      end
      if (nv.wr_ser) begin
        baud_next = nv.baud_val;
        dbits_next = nv.dbits_val;
        parity_next = nv.parity_val;
        term_next = nv.term_val;
        flow_next = nv.flow_val;
      end
    end
  end

  always_ff @(posedge clk) begin
    port_reg <= port_next;
    pad_reg <= pad_next;
    baud_reg <= baud_next;
    dbits_reg <= dbits_next;
    parity_reg <= parity_next;
    term_reg <= term_next;
    flow_reg <= flow_next;
    chg_reg <= chg_next;
  end

  assign nv.port_sel = port_reg;
  assign nv.pad = pad_reg;
  assign nv.baud = baud_reg;
  assign nv.dbits = dbits_reg;
  assign nv.parity = parity_reg;
  assign nv.term = term_reg;
  assign nv.flow = flow_reg;
  assign nv.port_changed = chg_reg;
endmodule : gric_nvstore
`default_nettype wire

/* File: hdl/gric_por.sv */
// Power-on sequencer: internal reset pulse then address display window.
`default_nettype none
module gric_por #(
  parameter int SHOW_CYC = gric_pkg::ADDR_SHOW_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  output logic core_rst_n,
  output logic show_addr
);
  gric_pkg::gric_pwr_t st_reg, st_next;
  logic [31:0] cnt_reg, cnt_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      gric_pkg::PS_RESET: begin
        cnt_next = cnt_reg + 32'h0000_0001;
        if (cnt_reg >= 32'(gric_pkg::POR_CYC - 1)) begin
          st_next = gric_pkg::PS_SHOW;
          cnt_next = 32'h0000_0000;
        end
      end
      gric_pkg::PS_SHOW: begin
        cnt_next = cnt_reg + 32'h0000_0001;
        if (cnt_reg >= 32'(SHOW_CYC - 1)) begin
          st_next = gric_pkg::PS_RUN;
        end
      end
      gric_pkg::PS_RUN: begin
        cnt_next = 32'h0000_0000;
      end
      default: begin
        st_next = gric_pkg::PS_RESET;
        cnt_next = 32'h0000_0000;
      end
    endcase
    if (restart) begin
      st_next = gric_pkg::PS_RESET;
      cnt_next = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= gric_pkg::PS_RESET;
      cnt_reg <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  assign core_rst_n = (st_reg != gric_pkg::PS_RESET);
  assign show_addr = (st_reg == gric_pkg::PS_SHOW);
endmodule : gric_por
`default_nettype wire

/* File: tb/gric_properties.sv */
// Concurrent checks on the ports of the remote interface control block.
`default_nettype none
module gric_properties #(
  parameter int SHOW_CYC = 8
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PANEL_PORT_WR,
  input wire logic PANEL_LOCAL_KEY,
  input wire logic PANEL_OUTPUT_OFF_KEY,
  input wire logic [7:0] PANEL_KEYS,
  input wire logic GPIB_REN,
  input wire logic GPIB_IFC,
  input wire logic GPIB_MSG_VALID,
  input wire logic [3:0] GPIB_MSG,
  input wire logic SEL_RS232,
  input wire logic GPIB_ENABLE,
  input wire logic RS232_ENABLE,
  input wire logic REMOTE_INDICATOR,
  input wire logic LOCKOUT,
  input wire logic TALK_INDICATOR,
  input wire logic LISTENER_INDICATOR,
  input wire logic [7:0] KEYS_OUT,
  input wire logic OUTPUT_OFF_REQ,
  input wire logic CLEAR_PULSE,
  input wire logic ARM_PULSE,
  input wire logic ACQ_GO
);
  // Counts cycles since reset or a port-select write, so that checks skip the
  // internal power-on sequence.
  logic [4:0] up_reg;
  logic [4:0] up_next;
  logic ready;
  logic msg_ok;
  assign ready = (up_reg == 5'h1F);
  assign msg_ok = ready && GPIB_ENABLE && GPIB_MSG_VALID;
  always_comb begin
    up_next = up_reg;
    if (PANEL_PORT_WR) up_next = 5'h00;
    else if (up_reg != 5'h1F) up_next = up_reg + 5'h01;
  end
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) up_reg <= 5'h00;
    else up_reg <= up_next;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  port_onehot_a: assert property (ready |-> GPIB_ENABLE != RS232_ENABLE)
    else $error("remote port enables not exclusive");
  rs232_deaf_a: assert property (SEL_RS232 && GPIB_MSG_VALID
    |=> !CLEAR_PULSE && !ARM_PULSE) else $error("bus message acted on");
  rem_cause_a: assert property ($rose(REMOTE_INDICATOR) |->
    $past(GPIB_REN) && $past(GPIB_MSG_VALID) && $past(GPIB_MSG) == 4'h1
    && LISTENER_INDICATOR) else $error("remote entered without listen");
  acq_remote_a: assert property (ACQ_GO |->
    $past(REMOTE_INDICATOR) || SEL_RS232) else $error("acquire in local");
  ifc_idle_a: assert property (msg_ok == 1'b0 && ready && GPIB_IFC
    && GPIB_ENABLE |=> !TALK_INDICATOR && !LISTENER_INDICATOR)
    else $error("talker or listener left active on clear");
  ifc_keep_a: assert property (ready && GPIB_IFC && GPIB_REN
    && REMOTE_INDICATOR && !GPIB_MSG_VALID && !PANEL_LOCAL_KEY
    |=> REMOTE_INDICATOR) else $error("interface clear dropped remote");
  offkey_a: assert property (ready && LOCKOUT |->
    OUTPUT_OFF_REQ == $past(PANEL_OUTPUT_OFF_KEY))
    else $error("output-off key blocked");
  keys_lock_a: assert property (ready && (REMOTE_INDICATOR || LOCKOUT)
    && $past(REMOTE_INDICATOR || LOCKOUT) |-> KEYS_OUT == 8'h00)
    else $error("panel keys pass while remote");
  keys_pass_a: assert property (ready && !REMOTE_INDICATOR && !LOCKOUT
    && $past(!REMOTE_INDICATOR && !LOCKOUT) |-> KEYS_OUT == $past(PANEL_KEYS))
    else $error("panel keys blocked while local");
  gtl_local_a: assert property (msg_ok && GPIB_MSG == 4'h6
    && LISTENER_INDICATOR |=> !REMOTE_INDICATOR && !LOCKOUT)
    else $error("go-to-local ignored");
  dcl_all_a: assert property (msg_ok && GPIB_MSG == 4'h7 |=> CLEAR_PULSE)
    else $error("device clear missed");
  sdc_addr_a: assert property (msg_ok && GPIB_MSG == 4'h8 |=>
    CLEAR_PULSE == $past(LISTENER_INDICATOR))
    else $error("selective clear wrong");
  arm_cause_a: assert property (ARM_PULSE |-> $past(GPIB_MSG_VALID)
    && $past(GPIB_MSG) == 4'h9 && $past(LISTENER_INDICATOR))
    else $error("arm without trigger");
endmodule : gric_properties
`default_nettype wire

/* File: tb/gric_ctl_model.sv */
// Behavioural bus controller that sends interface messages to the block.
`default_nettype none
module gric_ctl_model (
  input wire logic clk,
  output logic ren,
  output logic ifc,
  output logic valid,
  output logic [3:0] msg,
  output logic [4:0] maddr
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IFC_CYC = 10000;
  initial begin
    ren = 1'b0;
    ifc = 1'b0;
    valid = 1'b0;
    msg = 4'h0;
    maddr = 5'h00;
  end
  // Released message lines show the inverse so stale codes never match.
  task automatic send(input logic [3:0] m, input logic [4:0] a);
    @(posedge clk);
    valid <= 1'b1;
    msg <= m;
    maddr <= a;
    @(posedge clk);
    valid <= 1'b0;
    msg <= ~m;
    maddr <= ~a;
  endtask : send
  task automatic clear_bus();
    @(posedge clk);
    ifc <= 1'b1;
    repeat (IFC_CYC) @(posedge clk);
    ifc <= 1'b0;
  endtask : clear_bus
  task automatic set_ren(input logic v);
    @(posedge clk);
    ren <= v;
  endtask : set_ren
endmodule : gric_ctl_model
`default_nettype wire

/* File: tb/gric_top_tb.sv */
// Self-checking bench for the remote interface control block.
`default_nettype none
module gric_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SHOW = 8;
  logic REF_CLK, RST_N, NV_INIT_N, WR, RD, PANEL_PORT_WR, PANEL_PORT_VAL;
  logic PANEL_LOCAL_KEY, PANEL_OUTPUT_OFF_KEY, RS232_CMD_VALID;
  logic GPIB_REN, GPIB_IFC, GPIB_MSG_VALID, SEL_RS232, GPIB_ENABLE;
  logic RS232_ENABLE, REMOTE_INDICATOR, LOCKOUT, TALK_INDICATOR;
  logic LISTENER_INDICATOR, SHOW_ADDR, OUTPUT_OFF_REQ, CLEAR_PULSE;
  logic ARM_PULSE, SPOLL_ACTIVE, ACQ_GO, ACQ_REJECT, ABORT_PULSE;
  logic [3:0] ADDR, GPIB_MSG;
  logic [4:0] GPIB_MSG_ADDR, SHOW_PAD, m_pad;
  logic [7:0] PANEL_KEYS, KEYS_OUT, SPOLL_BYTE;
  logic [31:0] WDATA, RDATA, v;
  logic m_rem, m_llo, m_tact, m_lact;
  int mismatches, total_checks, n;
  gric_top #(.SHOW_CYC(SHOW)) dut (.*);
  gric_ctl_model u_ctl (.clk(REF_CLK), .ren(GPIB_REN), .ifc(GPIB_IFC),
    .valid(GPIB_MSG_VALID), .msg(GPIB_MSG), .maddr(GPIB_MSG_ADDR));
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge REF_CLK);
  endtask : cyc
  task automatic flags();
    chk({REMOTE_INDICATOR, LOCKOUT, TALK_INDICATOR, LISTENER_INDICATOR},
      {m_rem, m_llo, m_tact, m_lact});
  endtask : flags
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
    #1;
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask : rchk
  // Sends one message and updates the reference state of the flags.
  task automatic bus(input logic [3:0] m, input logic [4:0] a,
    input logic clr, input logic arm);
    u_ctl.send(m, a);
    #1;
    if (!SEL_RS232) begin
      case (m)
        4'h1: if (a == m_pad) begin
          m_lact = 1'b1;
          m_tact = 1'b0;
          m_rem = m_rem | GPIB_REN;
        end
        4'h2: begin
          m_tact = (a == m_pad);
          if (a == m_pad) m_lact = 1'b0;
        end
        4'h3: m_lact = 1'b0;
        4'h4, 4'hC: m_tact = 1'b0;
        4'h5: m_llo = 1'b1;
        4'h6: if (m_lact) begin
          m_rem = 1'b0;
          m_llo = 1'b0;
        end
        default: ;
      endcase
    end
    chk({CLEAR_PULSE, ARM_PULSE}, {clr, arm});
    flags();
  endtask : bus
  task automatic por_watch();
    n = 0;
    repeat (40) begin
      @(posedge REF_CLK);
      #1;
      if (SHOW_ADDR === 1'b1) n++;
    end
    m_rem = 1'b0;
    m_llo = 1'b0;
    m_tact = 1'b0;
    m_lact = 1'b0;
    chk(n, SHOW);
    flags();
  endtask : por_watch
  task automatic port_sel(input logic p);
    @(posedge REF_CLK);
    PANEL_PORT_WR <= 1'b1;
    PANEL_PORT_VAL <= p;
    @(posedge REF_CLK);
    PANEL_PORT_WR <= 1'b0;
    por_watch();
  endtask : port_sel
  initial begin
    repeat (40000) @(posedge REF_CLK);
    mismatches++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h0000_5bbc));
    {mismatches, total_checks} = '0;
    {RST_N, NV_INIT_N, WR, RD, PANEL_PORT_WR, PANEL_PORT_VAL} = '0;
    {PANEL_LOCAL_KEY, PANEL_OUTPUT_OFF_KEY, RS232_CMD_VALID} = '0;
    {ADDR, WDATA, PANEL_KEYS} = '0;
    m_pad = 5'h18;
    cyc(3);
    RST_N <= 1'b1;
    NV_INIT_N <= 1'b1;
    por_watch();
    chk(SHOW_PAD, 32'h0000_0018);
    rchk(4'h0, 32'h0000_0000);
    rchk(4'h4, 32'h0000_0018);
    rchk(4'h2, 32'h0000_2580);
    rchk(4'h3, 32'h0000_0D08);
    rchk(4'hF, 32'h0000_0000);
    u_ctl.set_ren(1'b1);
    cyc(3);
    bus(4'h1, m_pad ^ 5'h01, 1'b0, 1'b0);
    for (int k = 0; k < 6; k++) begin
      if (k == 3) bus(4'h1, m_pad, 1'b0, 1'b0);
      wr(4'h6, k % 3);
      chk({ACQ_GO, ACQ_REJECT}, (k < 3) ? 2'b01 : 2'b10);
    end
    wr(4'h6, 32'h0000_0003);
    chk({ACQ_GO, ACQ_REJECT, ABORT_PULSE}, 3'b001);
    PANEL_KEYS <= 8'($urandom) | 8'h01;
    cyc(2);
    #1 chk(KEYS_OUT, 32'h0000_0000);
    PANEL_LOCAL_KEY <= 1'b1;
    cyc(2);
    PANEL_LOCAL_KEY <= 1'b0;
    m_rem = 1'b0;
    cyc(2);
    #1 chk(KEYS_OUT, PANEL_KEYS);
    bus(4'h1, m_pad, 1'b0, 1'b0);
    bus(4'h5, 5'h00, 1'b0, 1'b0);
    {PANEL_LOCAL_KEY, PANEL_OUTPUT_OFF_KEY} <= 2'b11;
    cyc(3);
    #1 chk(OUTPUT_OFF_REQ, 32'h0000_0001);
    flags();
    {PANEL_LOCAL_KEY, PANEL_OUTPUT_OFF_KEY} <= 2'b00;
    bus(4'h6, 5'h00, 1'b0, 1'b0);
    bus(4'h2, m_pad, 1'b0, 1'b0);
    bus(4'hC, 5'h00, 1'b0, 1'b0);
    bus(4'h2, m_pad, 1'b0, 1'b0);
    bus(4'h4, 5'h00, 1'b0, 1'b0);
    bus(4'h1, m_pad, 1'b0, 1'b0);
    bus(4'h3, 5'h00, 1'b0, 1'b0);
    bus(4'h7, 5'h00, 1'b1, 1'b0);
    bus(4'h8, 5'h00, 1'b0, 1'b0);
    bus(4'h1, m_pad, 1'b0, 1'b0);
    bus(4'h8, 5'h00, 1'b1, 1'b0);
    wr(4'h1, 32'h0000_0000);
    bus(4'h9, 5'h00, 1'b0, 1'b0);
    wr(4'h1, 32'h0000_0001);
    bus(4'h9, 5'h00, 1'b0, 1'b1);
    bus(4'h7, 5'h00, 1'b1, 1'b0);
    v = $urandom;
    wr(4'h5, v);
    bus(4'hA, 5'h00, 1'b0, 1'b0);
    chk({SPOLL_ACTIVE, SPOLL_BYTE}, {1'b1, v[7:0]});
    bus(4'hB, 5'h00, 1'b0, 1'b0);
    chk(SPOLL_ACTIVE, 32'h0000_0000);
    bus(4'h2, m_pad, 1'b0, 1'b0);
    u_ctl.clear_bus();
    {m_tact, m_lact} = 2'b00;
    cyc(1);
    #1 flags();
    rchk(4'h1, 32'h0000_0001);
    n = $urandom_range(30);
    wr(4'h4, n);
    m_pad = n[4:0];
    wr(4'h4, 32'h0000_001F);
    rchk(4'h4, {27'h0, m_pad});
    bus(4'h1, m_pad, 1'b0, 1'b0);
    port_sel(1'b1);
    chk({SEL_RS232, RS232_ENABLE, GPIB_ENABLE}, 3'b110);
    bus(4'h7, 5'h00, 1'b0, 1'b0);
    wr(4'h6, 32'h0000_0000);
    chk(ACQ_GO, 32'h0000_0001);
    wr(4'h0, 32'hFFFF_FFFF);
    wr(4'h1, 32'hFFFF_FFFE);
    chk(SEL_RS232, 32'h0000_0001);
    RST_N <= 1'b0;
    cyc(2);
    RST_N <= 1'b1;
    por_watch();
    chk(SEL_RS232, 32'h0000_0001);
    rchk(4'h4, {27'h0, m_pad});
    port_sel(1'b0);
    chk({SEL_RS232, GPIB_ENABLE}, 2'b01);
    print_verdict();
  end
endmodule : gric_top_tb
bind gric_top gric_properties #(.SHOW_CYC(SHOW_CYC)) u_props (.*);
`default_nettype wire
